// File: quad_reload_timer.sv
// Four-channel 8-bit up-counting reload timer with AXI4-Lite registers.
// Assumes sub_clk_i, ext_clk_i and hw_standby_i are asynchronous pins.
// Operation
// R1 - Control bit 7 picks interval counting (0) or auto reload (1).
// R2 - Counter roll from ff to 00 sets overflow flag, bit 6.
// R3 - Flag cleared by read-while-set then write zero; one ignored.
// R4 - Bit 5 enables the overflow interrupt request of the channel.
// R5 - Control bits 4 and 3 read as one, writes ignored.
// R6 - Channels 4,6 clocks: sys/32768,/2048,/128,/8, sub/256,/64,/8.
// R7 - Channels 5,7 clocks: sys/8192,/512,/32,/2, sub/128,/32,/2.
// R8 - Code 111 counts next channel overflow; channel 7 external edges.
// R9 - Counter is readable 8-bit up-counter, loaded only via reload.
// R10 - Pairs 4/5 and 6/7 share a word, lower channel upper byte.
// R11 - Counters clear on reset and in hardware standby.
// R12 - Writing reload value loads it into the counter too.
// R13 - Auto reload refills from reload register; period 1 to 256.
// R14 - Reload registers write-only, cleared on reset and standby.
// R15 - Interval style wraps to zero and keeps counting.
// R16 - Cascade runs on clock of least significant cascaded channel.
// R17 - Only the most significant cascaded channel sets its flag.
// R18 - Zero write clears flag only after it was read as set.
`timescale 1ns/1ps
module quad_reload_timer
  import reload_timer_pkg::*;
(
  input  wire logic                core_clk_i,
  input  wire logic                rst_b_i,
  input  wire logic                awvalid_i,
  output logic                     awready_o,
  input  wire logic [ADDR_W-1:0]   awaddr_i,
  input  wire logic                wvalid_i,
  output logic                     wready_o,
  input  wire logic [31:0]         wdata_i,
  input  wire logic [3:0]          wstrb_i,
  output logic                     bvalid_o,
  input  wire logic                bready_i,
  output logic [1:0]               bresp_o,
  input  wire logic                arvalid_i,
  output logic                     arready_o,
  input  wire logic [ADDR_W-1:0]   araddr_i,
  output logic                     rvalid_o,
  input  wire logic                rready_i,
  output logic [31:0]              rdata_o,
  output logic [1:0]               rresp_o,
  input  wire logic                sub_clk_i,
  input  wire logic                ext_clk_i,
  input  wire logic                hw_standby_i,
  output logic [NUM_CH-1:0]        overflow_irq_request_o,
  output logic                     irq_o
);
  if (SYS_PRE_W < 15 || SUB_PRE_W < 8 || NUM_CH != 4)
    $error("prescaler too short or channel count unsupported");

  logic [SYS_PRE_W-1:0]    sys_pre;
  logic [SUB_PRE_W-1:0]    sub_pre;
  logic [2:0]              sub_sync;
  logic [2:0]              ext_sync;
  logic [1:0]              stby_sync;
  logic                    standby;
  logic                    sub_edge;
  logic                    ext_edge;
  logic [3:0][7:0]         cnt;
  logic [3:0][7:0]         reload;
  logic [3:0][7:0]         new_reload;
  logic [3:0][2:0]         cks;
  logic [3:0]              auto_rld;
  logic [3:0]              ovf;
  logic [3:0]              overflow_irq_enable;
  logic [3:0]              ovf_armed;
  logic [3:0]              tick;
  logic [3:0]              ovf_ev;
  logic [3:0]              ovf_set_ev;
  logic [3:0]              casc;
  logic [3:0]              eff_auto_reload_select;
  logic [3:0][1:0]         top;
  logic [3:0]              load;
  logic [3:0]              reload_now;
  logic [3:0]              wr_rld;
  logic [3:0]              wr_ctrl;
  logic [3:0]              irq_stat;
  logic [3:0]              irq_mask;
  logic                    aw_held;
  logic                    w_held;
  logic [ADDR_W-1:0]       aw_addr;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;
  logic                    do_write;
  logic                    wr_ok;
  logic [31:0]             rd_data_c;
  logic                    rd_ok;
  logic [ADDR_W-1:0]       wa;
  logic [ADDR_W-1:0]       ra;

  function automatic logic tap(input logic [SYS_PRE_W-1:0] pre,
                               input int k);
    logic [SYS_PRE_W-1:0] m;
    m = SYS_PRE_W'((32'd1 << k) - 32'd1);
    return (pre & m) == m;
  endfunction

  // Pin synchronisers; only the second stage onward feeds logic
  always_ff @(posedge core_clk_i)
    if (!rst_b_i)
    begin
      sub_sync  <= 3'h0;
      ext_sync  <= 3'h0;
      stby_sync <= 2'h0;
    end
    else
    begin
      sub_sync  <= {sub_sync[1:0], sub_clk_i};
      ext_sync  <= {ext_sync[1:0], ext_clk_i};
      stby_sync <= {stby_sync[0], hw_standby_i};
    end

  assign standby  = stby_sync[1];
  assign sub_edge = sub_sync[1] & ~sub_sync[2];
  assign ext_edge = ext_sync[1] & ~ext_sync[2];

  always_ff @(posedge core_clk_i)
    if (!rst_b_i)
      sys_pre <= '0;
    else
      sys_pre <= sys_pre + 1'b1;

  always_ff @(posedge core_clk_i)
    if (!rst_b_i)
      sub_pre <= '0;
    else if (sub_edge)
      sub_pre <= sub_pre + 1'b1;

  // Count sources, walked from channel 7 down to channel 4 so cascades ripple
  always_comb
  begin
    tick   = '0;
    ovf_ev = '0;
    for (int i = NUM_CH - 1; i >= 0; i--)
    begin
      case (cks[i])
        3'h0, 3'h1, 3'h2, 3'h3:
          tick[i] = tap(sys_pre, i[0] ? SYS_LOG2_ODD[cks[i][1:0]]
                                      : SYS_LOG2_EVEN[cks[i][1:0]]); // R6 R7
        3'h4, 3'h5, 3'h6:
          tick[i] = sub_edge && tap(SYS_PRE_W'(sub_pre),
                      i[0] ? SUB_LOG2_ODD[cks[i][1:0]]
                           : SUB_LOG2_EVEN[cks[i][1:0]]); // R6 R7
        default:
          tick[i] = (i == NUM_CH - 1) ? ext_edge
                                      : ovf_ev[(i + 1) % NUM_CH]; // R8 R16
      endcase
      ovf_ev[i] = tick[i] && (cnt[i] == 8'hff) && !standby;
    end
  end

  // Chain structure: top is the most significant member of a chain
  always_comb
  begin
    casc       = '0;
    eff_auto_reload_select   = '0;
    top        = '0;
    ovf_set_ev = '0;
    reload_now = '0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      casc[i] = (i < NUM_CH - 1) && (cks[i] == CKS_CASCADE);
      if (i > 0 && casc[i-1])
      begin
        top[i]      = top[i-1];
        eff_auto_reload_select[i] = eff_auto_reload_select[i-1];
      end
      else
      begin
        top[i]      = 2'(i);
        eff_auto_reload_select[i] = auto_rld[i]; // R1
      end
      ovf_set_ev[i] = ovf_ev[i] && !(i > 0 && casc[i-1]); // R17
    end
    for (int i = 0; i < NUM_CH; i++)
      reload_now[i] = eff_auto_reload_select[i] && ovf_ev[top[i]]; // R13
  end

  // Reload write reaches the whole chain at once
  always_comb
  begin
    load       = '0;
    new_reload = reload;
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (wr_rld[i])
        new_reload[i] = i[0] ? w_data[7:0] : w_data[15:8]; // R10
      for (int j = 0; j < NUM_CH; j++)
        if (wr_rld[j] && top[j] == top[i])
          load[i] = 1'b1; // R12
    end
  end

  // Write beats may arrive in either order; hold each until both
  assign awready_o = !aw_held && !bvalid_o;
  assign wready_o  = !w_held && !bvalid_o;
  assign do_write  = aw_held && w_held && !bvalid_o;
  assign wa        = {aw_addr[ADDR_W-1:2], 2'h0};
  assign ra        = {araddr_i[ADDR_W-1:2], 2'h0};

  always_ff @(posedge core_clk_i)
    if (!rst_b_i)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end
    else if (awvalid_i && awready_o)
    begin
      aw_held <= 1'b1;
      aw_addr <= awaddr_i;
    end
    else if (do_write)
      aw_held <= 1'b0;

  always_ff @(posedge core_clk_i)
    if (!rst_b_i)
    begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end
    else if (wvalid_i && wready_o)
    begin
      w_held <= 1'b1;
      w_data <= wdata_i;
      w_strb <= wstrb_i;
    end
    else if (do_write)
      w_held <= 1'b0;

  always_comb
  begin
    wr_ctrl = '0;
    wr_rld  = '0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      wr_ctrl[i] = do_write && w_strb[0]
                   && wa == CTRL_BASE + ADDR_W'(4 * i);
      wr_rld[i]  = do_write && w_strb[i[0] ? 0 : 1]
                   && wa == (i < 2 ? RELOAD_45 : RELOAD_67); // R10
    end
    wr_ok = (wa[7:4] == CTRL_BASE[7:4]) || wa == COUNT_45_ADDR
            || wa == COUNT_67_ADDR || wa == RELOAD_45
            || wa == RELOAD_67 || wa == IRQ_STAT_ADDR
            || wa == IRQ_MASK_ADDR;
  end

  always_ff @(posedge core_clk_i)
    if (!rst_b_i)
    begin
      bvalid_o <= 1'b0;
      bresp_o  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_o <= 1'b1;
      bresp_o  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready_i)
      bvalid_o <= 1'b0;

  // Read mux; counters are read-only, reload registers read zero
  always_comb
  begin
    rd_data_c = '0;
    rd_ok     = 1'b1;
    if (ra[7:4] == CTRL_BASE[7:4])
      rd_data_c[7:0] = {auto_rld[ra[3:2]], ovf[ra[3:2]],
                        overflow_irq_enable[ra[3:2]], RSV_BITS, cks[ra[3:2]]}; // R5
    else if (ra == COUNT_45_ADDR)
      rd_data_c[15:0] = {cnt[0], cnt[1]}; // R9 R10
    else if (ra == COUNT_67_ADDR)
      rd_data_c[15:0] = {cnt[2], cnt[3]}; // R9 R10
    else if (ra == IRQ_STAT_ADDR)
      rd_data_c[3:0] = irq_stat;
    else if (ra == IRQ_MASK_ADDR)
      rd_data_c[3:0] = irq_mask;
    else if (ra != RELOAD_45 && ra != RELOAD_67)
      rd_ok = 1'b0;
  end

  assign arready_o = !rvalid_o;

  always_ff @(posedge core_clk_i)
    if (!rst_b_i)
    begin
      rvalid_o <= 1'b0;
      rdata_o  <= '0;
      rresp_o  <= RESP_OKAY;
    end
    else if (arvalid_i && arready_o)
    begin
      rvalid_o <= 1'b1;
      rdata_o  <= rd_data_c;
      rresp_o  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rready_i)
      rvalid_o <= 1'b0;

  // Arm on a read that saw the flag set; any control write disarms
  always_ff @(posedge core_clk_i)
    if (!rst_b_i)
      ovf_armed <= '0;
    else
      for (int i = 0; i < NUM_CH; i++)
        if (wr_ctrl[i])
          ovf_armed[i] <= 1'b0;
        else if (arvalid_i && arready_o && ovf[i]
                 && ra == CTRL_BASE + ADDR_W'(4 * i))
          ovf_armed[i] <= 1'b1; // R18

  always_ff @(posedge core_clk_i)
    if (!rst_b_i)
    begin
      auto_rld <= '0;
      overflow_irq_enable     <= '0;
      cks      <= '0;
    end
    else
      for (int i = 0; i < NUM_CH; i++)
        if (wr_ctrl[i])
        begin
          auto_rld[i] <= w_data[AUTO_RLD_BIT]; // R1
          overflow_irq_enable[i]     <= w_data[OVERFLOW_IRQ_ENABLE_BIT];
          cks[i]      <= w_data[CKS_MSB:0];
        end

  // Set beats clear; writing one never sets
  always_ff @(posedge core_clk_i)
    if (!rst_b_i)
      ovf <= '0;
    else
      for (int i = 0; i < NUM_CH; i++)
        if (ovf_set_ev[i])
          ovf[i] <= 1'b1; // R2
        else if (wr_ctrl[i] && !w_data[OVF_BIT] && ovf_armed[i])
          ovf[i] <= 1'b0; // R3 R18

  always_ff @(posedge core_clk_i)
    if (!rst_b_i || standby)
      reload <= {NUM_CH{RELOAD_RESET}}; // R14
    else
      reload <= new_reload;

  // A reload write wins over a count or automatic reload
  always_ff @(posedge core_clk_i)
    if (!rst_b_i || standby)
      cnt <= {NUM_CH{COUNT_RESET}}; // R11
    else
      for (int i = 0; i < NUM_CH; i++)
        if (load[i])
          cnt[i] <= new_reload[i]; // R12
        else if (reload_now[i])
          cnt[i] <= reload[i]; // R13
        else if (tick[i])
          cnt[i] <= cnt[i] + 8'h01; // R9 R15

  always_ff @(posedge core_clk_i)
    if (!rst_b_i)
      irq_mask <= MASK_RESET;
    else if (do_write && w_strb[0] && wa == IRQ_MASK_ADDR)
      irq_mask <= w_data[3:0];

  always_ff @(posedge core_clk_i)
    if (!rst_b_i)
      irq_stat <= '0;
    else
    begin
      if (do_write && w_strb[0] && wa == IRQ_STAT_ADDR)
        irq_stat <= (irq_stat & ~w_data[3:0]) | ovf_set_ev;
      else
        irq_stat <= irq_stat | ovf_set_ev;
    end

  assign overflow_irq_request_o = ovf & overflow_irq_enable; // R4
  assign irq_o                  = |(irq_stat & irq_mask);

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_write_taken;
    do_write;
  endsequence
  sequence s_resp_held;
    bvalid_o [*2];
  endsequence

  a_write_resp: assert property (s_write_taken |=> bvalid_o)
    else $error("write response missing");
  a_resp_hold: assert property (bvalid_o && !bready_i |-> s_resp_held)
    else $error("write response dropped early");
  a_flag_set: assert property (ovf_set_ev[3] |=> ovf[3]) // R2
    else $error("overflow flag not set");
  a_one_write_ignored: assert property (wr_ctrl[0] && w_data[OVF_BIT] // R3
    && !ovf[0] && !ovf_set_ev[0] |=> !ovf[0])
    else $error("flag set by software");
  a_clear_needs_read: assert property (wr_ctrl[3] && !ovf_armed[3] // R18
    && ovf[3] |=> ovf[3])
    else $error("flag cleared without read");
  a_irq_gate: assert property (ovf[2] && !overflow_irq_enable[2] // R4
    |-> !overflow_irq_request_o[2])
    else $error("masked request asserted");
  a_reserved_ones: assert property (arvalid_i && arready_o // R5
    && ra == CTRL_BASE |=> rdata_o[4:3] == RSV_BITS)
    else $error("reserved bits not one");
  a_reload_load: assert property (wr_rld[1] && !standby // R12
    |=> cnt[1] == $past(w_data[7:0]))
    else $error("reload write not loaded");
  a_auto_refill: assert property (reload_now[3] && !load[3] // R13
    && !standby |=> cnt[3] == $past(reload[3]))
    else $error("auto reload missed");
  a_interval_wrap: assert property (ovf_ev[3] && !eff_auto_reload_select[3] // R15
    && !load[3] |=> cnt[3] == 8'h00)
    else $error("interval wrap wrong");
  a_standby_clear: assert property (standby // R11 R14
    |=> cnt == '0 && reload == '0)
    else $error("standby did not clear");
  a_cascade_flag: assert property (casc[2] && ovf_ev[3] && !ovf[3] // R17
    |=> !ovf[3])
    else $error("inner cascade flag set");
endmodule

// File: reload_timer_pkg.sv
// Package for the four-channel 8-bit reload timer.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package reload_timer_pkg;
  localparam int          NUM_CH        = 4;
  localparam int          ADDR_W        = 8;
  localparam int          SYS_PRE_W     = 15;
  localparam int          SUB_PRE_W     = 8;
  // Register byte addresses
  localparam logic [7:0]  CTRL_BASE     = 8'h00;
  localparam logic [7:0]  COUNT_45_ADDR = 8'h10;
  localparam logic [7:0]  COUNT_67_ADDR = 8'h14;
  localparam logic [7:0]  RELOAD_45     = 8'h18;
  localparam logic [7:0]  RELOAD_67     = 8'h1c;
  localparam logic [7:0]  IRQ_STAT_ADDR = 8'h20;
  localparam logic [7:0]  IRQ_MASK_ADDR = 8'h24;
  // Control field positions
  localparam int          AUTO_RLD_BIT  = 7;
  localparam int          OVF_BIT       = 6;
  localparam int          OVERFLOW_IRQ_ENABLE_BIT      = 5;
  localparam int          CKS_MSB       = 2;
  localparam logic [1:0]  RSV_BITS      = 2'h3;
  localparam logic [2:0]  CKS_CASCADE   = 3'h7;
  // Reset values
  localparam logic [7:0]  COUNT_RESET   = 8'h00;
  localparam logic [7:0]  RELOAD_RESET  = 8'h00;
  localparam logic [3:0]  MASK_RESET    = 4'h0;
  // Divider exponents, indexed by clock-select code
  localparam int SYS_LOG2_EVEN [4] = '{15, 11, 7, 3};
  localparam int SYS_LOG2_ODD  [4] = '{13, 9, 5, 1};
  localparam int SUB_LOG2_EVEN [3] = '{8, 6, 3};
  localparam int SUB_LOG2_ODD  [3] = '{7, 5, 1};
  // Bus responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// File: testbench.sv
// Self-checking bench for the four-channel reload timer.
// Assumes the AXI4-Lite map and timing of the designer's note.
`timescale 1ns/1ps
module testbench
  import reload_timer_pkg::*;
;
  logic                  core_clk_i   = 1'b0;
  logic                  rst_b_i      = 1'b0;
  logic                  awvalid_i    = 1'b0;
  logic                  wvalid_i     = 1'b0;
  logic                  bready_i     = 1'b0;
  logic                  arvalid_i    = 1'b0;
  logic                  rready_i     = 1'b0;
  logic                  sub_clk_i    = 1'b0;
  logic                  ext_clk_i    = 1'b0;
  logic                  hw_standby_i = 1'b0;
  logic [ADDR_W-1:0]     awaddr_i     = '0;
  logic [ADDR_W-1:0]     araddr_i     = '0;
  logic [31:0]           wdata_i      = '0;
  logic [3:0]            wstrb_i      = '0;
  logic                  awready_o;
  logic                  wready_o;
  logic                  bvalid_o;
  logic                  arready_o;
  logic                  rvalid_o;
  logic                  irq_o;
  logic [1:0]            bresp_o;
  logic [1:0]            rresp_o;
  logic [1:0]            rsp;
  logic [31:0]           rdata_o;
  logic [31:0]           rdat;
  logic [NUM_CH-1:0]     overflow_irq_request_o;
  int                    n_mismatch   = 0;
  int                    checks_done  = 0;

  typedef struct packed
  {
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [7:0]  ra;
    logic [31:0] ex;
  } row_t;

  // Write one register, read one back
  row_t rows [8] = '{
    '{8'h00, 32'h000000ff, 8'h00, 32'h000000bf},
    '{8'h00, 32'h00000000, 8'h00, 32'h00000018},
    '{8'h04, 32'h00000025, 8'h04, 32'h0000003d},
    '{8'h14, 32'h0000ffff, 8'h14, 32'h00000000},
    '{8'h18, 32'h00001234, 8'h10, 32'h00001234},
    '{8'h18, 32'h00000000, 8'h18, 32'h00000000},
    '{8'h24, 32'h0000000f, 8'h24, 32'h0000000f},
    '{8'h24, 32'h00000000, 8'h24, 32'h00000000}
  };

  quad_reload_timer dut
  (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .awvalid_i(awvalid_i), .awready_o(awready_o), .awaddr_i(awaddr_i),
    .wvalid_i(wvalid_i), .wready_o(wready_o), .wdata_i(wdata_i),
    .wstrb_i(wstrb_i), .bvalid_o(bvalid_o), .bready_i(bready_i),
    .bresp_o(bresp_o), .arvalid_i(arvalid_i), .arready_o(arready_o),
    .araddr_i(araddr_i), .rvalid_o(rvalid_o), .rready_i(rready_i),
    .rdata_o(rdata_o), .rresp_o(rresp_o), .sub_clk_i(sub_clk_i),
    .ext_clk_i(ext_clk_i), .hw_standby_i(hw_standby_i),
    .overflow_irq_request_o(overflow_irq_request_o), .irq_o(irq_o)
  );

  always #50 core_clk_i = ~core_clk_i;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Ready is sampled at the falling edge: it cannot move before the rise
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic ta, tw, ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awaddr_i  <= a;
    wdata_i   <= d;
    wstrb_i   <= s;
    awvalid_i <= 1'b1;
    wvalid_i  <= 1'b1;
    bready_i  <= 1'b1;
    while (!(ad && dd))
    begin
      @(negedge core_clk_i);
      ta = awvalid_i && awready_o;
      tw = wvalid_i && wready_o;
      @(posedge core_clk_i);
      if (ta) awvalid_i <= 1'b0;
      if (tw) wvalid_i <= 1'b0;
      ad = ad | ta;
      dd = dd | tw;
    end
    do
    begin
      @(negedge core_clk_i);
      ta  = bvalid_o;
      rsp = bresp_o;
      @(posedge core_clk_i);
    end while (!ta);
    bready_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic rd(input logic [7:0] a);
    logic t;
    araddr_i  <= a;
    arvalid_i <= 1'b1;
    rready_i  <= 1'b1;
    do
    begin
      @(negedge core_clk_i);
      t = arready_o;
      @(posedge core_clk_i);
    end while (!t);
    arvalid_i <= 1'b0;
    do
    begin
      @(negedge core_clk_i);
      t    = rvalid_o;
      rdat = rdata_o;
      rsp  = rresp_o;
      @(posedge core_clk_i);
    end while (!t);
    rready_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  // Slow edges so the pin synchroniser sees every one
  task automatic pulse(input int n, input bit sub);
    repeat (n)
    begin
      if (sub)
        sub_clk_i <= 1'b1;
      else
        ext_clk_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      if (sub)
        sub_clk_i <= 1'b0;
      else
        ext_clk_i <= 1'b0;
      repeat (4) @(posedge core_clk_i);
    end
    repeat (4) @(posedge core_clk_i);
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge core_clk_i);
    n_mismatch++;
    summarize();
  end

  initial
  begin
    repeat (10) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    @(posedge core_clk_i);
    rd(CTRL_BASE + 8'h0c);
    chk(rdat, 32'h18);
    rd(COUNT_67_ADDR);
    chk(rdat, 32'h0);
    foreach (rows[i])
    begin
      wr(rows[i].wa, rows[i].wd, 4'hf);
      chk({30'h0, rsp}, {30'h0, RESP_OKAY});
      rd(rows[i].ra);
      chk(rdat, rows[i].ex);
    end
    // Channel 7 on external edges, interval style
    wr(CTRL_BASE + 8'h0c, 32'h07, 4'h1);
    wr(RELOAD_67, 32'h00fe, 4'h3);
    rd(COUNT_67_ADDR);
    chk(rdat, 32'h00fe);
    pulse(3, 1'b0);
    rd(COUNT_67_ADDR);
    chk(rdat, 32'h0001);
    rd(IRQ_STAT_ADDR);
    chk(rdat, 32'h8);
    chk({31'h0, irq_o}, 32'h0);
    wr(IRQ_MASK_ADDR, 32'h8, 4'hf);
    chk({31'h0, irq_o}, 32'h1);
    wr(IRQ_STAT_ADDR, 32'h8, 4'hf);
    chk({31'h0, irq_o}, 32'h0);
    // Zero writes without a prior read must leave the flag set
    wr(CTRL_BASE + 8'h0c, 32'h27, 4'h1);
    chk({28'h0, overflow_irq_request_o}, 32'h8);
    wr(CTRL_BASE + 8'h0c, 32'h07, 4'h1);
    chk({28'h0, overflow_irq_request_o}, 32'h0);
    rd(CTRL_BASE + 8'h0c);
    chk(rdat, 32'h5f);
    wr(CTRL_BASE + 8'h0c, 32'h07, 4'h1);
    rd(CTRL_BASE + 8'h0c);
    chk(rdat, 32'h1f);
    // Auto reload: fe, ff, reload fe, ff
    wr(CTRL_BASE + 8'h0c, 32'h87, 4'h1);
    wr(RELOAD_67, 32'h00fe, 4'h3);
    pulse(3, 1'b0);
    rd(COUNT_67_ADDR);
    chk(rdat, 32'h00ff);
    rd(CTRL_BASE + 8'h0c);
    chk(rdat, 32'hdf);
    wr(CTRL_BASE + 8'h0c, 32'h07, 4'h1);
    // Cascade 6 on 7: one edge wraps the whole 16-bit chain
    wr(CTRL_BASE + 8'h08, 32'h07, 4'h1);
    wr(RELOAD_67, 32'hffff, 4'h3);
    pulse(1, 1'b0);
    rd(COUNT_67_ADDR);
    chk(rdat, 32'h0000);
    rd(CTRL_BASE + 8'h0c);
    chk(rdat, 32'h1f);
    rd(CTRL_BASE + 8'h08);
    chk(rdat, 32'h5f);
    // Standby clears counters
    wr(RELOAD_45, 32'h1234, 4'h3);
    hw_standby_i <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    hw_standby_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    rd(COUNT_45_ADDR);
    chk(rdat, 32'h0);
    // Upper-lane write loads the chain; the lower half shows its reload
    wr(RELOAD_67, 32'h0500, 4'h2);
    rd(COUNT_67_ADDR);
    chk(rdat, 32'h0500);
    // Subclock taps: eight edges give one /8 and four /2 counts
    wr(CTRL_BASE, 32'h06, 4'h1);
    wr(CTRL_BASE + 8'h04, 32'h06, 4'h1);
    wr(RELOAD_45, 32'h0000, 4'h3);
    pulse(8, 1'b1);
    rd(COUNT_45_ADDR);
    chk(rdat, 32'h0104);
    // Unmapped place answers with an error
    wr(8'h40, 32'h1, 4'hf);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    rd(8'h40);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    // Reset in mid-run clears counters and control
    rst_b_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    @(posedge core_clk_i);
    rd(COUNT_45_ADDR);
    chk(rdat, 32'h0);
    rd(CTRL_BASE + 8'h04);
    chk(rdat, 32'h18);
    summarize();
  end
endmodule
